// *** arith_adder.sv ***
// sized adder and subtractor producing result and flags
`timescale 1ns/1ps
module arith_adder
	import arith_pkg::*;
(
	// operands
	input  wire logic [31:0] a_i,
	input  wire logic [31:0] b_i,
	input  wire logic        cin_i,
	input  wire logic        sub_i,
	input  wire op_size_t    size_i,
	// result
	output logic      [31:0] sum_o,
	output logic      [3:0]  nzvc_o,
	output logic             half_o
);
	// ----------------------------------------
	// add with width-aware flags
	// ----------------------------------------
	logic [32:0] full;
	logic [31:0] bb;
	logic [4:0]  nib;
	logic [31:0] res;
	logic        c;
	logic        v;
	logic        n;
	logic        z;
	always_comb begin
		bb = sub_i ? ~b_i : b_i;
		full = {1'b0, a_i} + {1'b0, bb} + {32'h0, (cin_i ^ sub_i)};
		nib = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, (cin_i ^ sub_i)};
		res = full[31:0];
		c = 1'b0;
		v = 1'b0;
		n = 1'b0;
		z = 1'b0;
		half_o = nib[4] ^ sub_i;
		unique case (size_i)
			SZ_BYTE: begin
				res = {24'h0, full[7:0]};
				c = (a_i[8] ^ bb[8] ^ full[8]) ^ sub_i;
				n = full[7];
				z = (full[7:0] == 8'h00);
				v = (a_i[7] == bb[7]) && (full[7] != a_i[7]);
			end
			SZ_WORD: begin
				res = {16'h0, full[15:0]};
				c = (a_i[16] ^ bb[16] ^ full[16]) ^ sub_i;
				n = full[15];
				z = (full[15:0] == 16'h0000);
				v = (a_i[15] == bb[15]) && (full[15] != a_i[15]);
			end
			default: begin
				c = full[32] ^ sub_i;
				n = full[31];
				z = (full[31:0] == 32'h0);
				v = (a_i[31] == bb[31]) && (full[31] != a_i[31]);
			end
		endcase
		sum_o = res;
		nzvc_o = {n, z, v, c};
	end
endmodule

// *** arith_datapath.sv ***
// arithmetic and data transfer datapath of the cpu core
// Notes on behaviour
// RULE_01: add or subtract byte/word/long, register or immediate source, into destination.
// RULE_02: subtracting an immediate byte from a register is refused as illegal.
// RULE_03: byte-only add-with-carry and subtract-with-borrow fold in the carry flag.
// RULE_04: increment/decrement by 1 or 2 for word/long; byte only by 1.
// RULE_05: add or subtract constant 1, 2 or 4 on the full 32-bit register.
// RULE_06: decimal adjust corrects a byte into packed BCD using carry and half-carry.
// RULE_07: unsigned multiply, 8x8 to 16 or 16x16 to 32 bits.
// RULE_08: signed multiply, two's complement, 8x8 to 16 or 16x16 to 32.
// RULE_09: unsigned divide 16/8 or 32/16 giving quotient and remainder.
// RULE_10: signed divide, same sizes, two's complement quotient and remainder.
// RULE_11: compare subtracts and updates flags only, no write-back.
// RULE_12: negate replaces register with zero minus its value.
// RULE_13: move register to register, register to memory, memory or immediate to register.
// RULE_14: stack restore is a load through stack pointer with post-increment.
// RULE_15: stack save is a store through stack pointer with pre-decrement.
// RULE_16: peripheral-synchronised byte moves are unsupported and flagged illegal.
// RULE_17: word and long memory addresses have their lowest bit forced to zero.
// RULE_18: software keeps the stack pointer even and uses word or long stack access.
// RULE_19: arithmetic updates negative, zero, overflow and carry per operand size; code keeps carry on inc/dec, none on small constants or unsigned multiply.
`timescale 1ns/1ps
module arith_datapath
	import arith_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_B_I,
	// request from decoder
	input  wire logic        REQ_VALID_I,
	input  wire op_req_t     REQ_I,
	// memory load data for load and restore operations
	input  wire logic [31:0] MEM_RDATA_I,
	// result to register file and memory
	output logic             RES_VALID_O,
	output op_res_t          RES_O,
	// condition flags
	output logic      [7:0]  FLAGS_O
);
	// ----------------------------------------
	// operand shaping
	// ----------------------------------------
	logic [31:0] opnd_b;
	logic [31:0] dst_sized;
	logic [7:0]  flags;
	always_comb begin
		opnd_b = REQ_I.use_imm ? REQ_I.imm : REQ_I.src;
		unique case (REQ_I.size)
			SZ_BYTE: dst_sized = {24'h0, REQ_I.dst[7:0]};
			SZ_WORD: dst_sized = {16'h0, REQ_I.dst[15:0]};
			default: dst_sized = REQ_I.dst;
		endcase
	end

	// ----------------------------------------
	// adder operand selection
	// ----------------------------------------
	logic [31:0] add_a;
	logic [31:0] add_b;
	logic        add_cin;
	logic        add_sub;
	op_size_t    add_size;
	logic [31:0] add_sum;
	logic [3:0]  add_nzvc;
	logic        add_half;
	always_comb begin
		// sized destination: upper bits read as zero so the flags see only the operand
		add_a = dst_sized; // [RULE_01]
		add_b = opnd_b;
		add_cin = 1'b0;
		add_sub = 1'b0;
		add_size = REQ_I.size;
		unique case (REQ_I.op)
			OP_SUB, OP_COMPARE: add_sub = 1'b1; // [RULE_01] [RULE_11]
			OP_ADD_CARRY: begin
				add_cin = flags[FLG_C]; // [RULE_03]
				add_size = SZ_BYTE;
			end
			OP_SUB_BORROW: begin
				add_sub = 1'b1;
				add_cin = flags[FLG_C]; // [RULE_03]
				add_size = SZ_BYTE;
			end
			OP_PLUS12, OP_MINUS12: begin
				add_sub = (REQ_I.op == OP_MINUS12);
				// byte form only steps by one
				add_b = (REQ_I.size == SZ_BYTE || REQ_I.small_const != 3'h2) ?
					32'h1 : 32'h2; // [RULE_04]
			end
			OP_NEGATE: begin
				add_a = 32'h0;
				add_b = REQ_I.dst;
				add_sub = 1'b1; // [RULE_12]
			end
			default: ;
		endcase
	end

	arith_adder u_adder (
		.a_i    (add_a),
		.b_i    (add_b),
		.cin_i  (add_cin),
		.sub_i  (add_sub),
		.size_i (add_size),
		.sum_o  (add_sum),
		.nzvc_o (add_nzvc),
		.half_o (add_half)
	);

	// ----------------------------------------
	// small constants, decimal adjust, multiply
	// ----------------------------------------
	logic [31:0] small_val;
	logic [31:0] small_res;
	logic [7:0]  dadj_res;
	logic        dadj_c;
	logic [31:0] mul_res;
	always_comb begin
		unique case (REQ_I.small_const)
			3'h4:    small_val = 32'h4;
			3'h2:    small_val = 32'h2;
			default: small_val = 32'h1;
		endcase
		// full 32 bits regardless of the requested size, flags untouched
		small_res = (REQ_I.op == OP_SUB_SMALL) ? REQ_I.dst - small_val :
			REQ_I.dst + small_val; // [RULE_05]
	end

	always_comb begin
		logic [7:0] corr;
		logic       lo_adj;
		logic       hi_adj;
		corr = 8'h00;
		lo_adj = flags[FLG_H] || (REQ_I.dst[3:0] > 4'h9);
		hi_adj = flags[FLG_C] || (REQ_I.dst[7:0] > 8'h99);
		if (REQ_I.op == OP_DADJ_SUB) begin
			lo_adj = flags[FLG_H];
			hi_adj = flags[FLG_C];
		end
		if (lo_adj) begin
			corr[3:0] = 4'h6;
		end
		if (hi_adj) begin
			corr[7:4] = 4'h6;
		end
		dadj_res = (REQ_I.op == OP_DADJ_SUB) ? REQ_I.dst[7:0] - corr :
			REQ_I.dst[7:0] + corr; // [RULE_06]
		dadj_c = hi_adj;
	end

	always_comb begin
		logic signed [31:0] sprod;
		logic        [31:0] uprod;
		sprod = 32'sh0;
		uprod = 32'h0;
		mul_res = 32'h0;
		if (REQ_I.size == SZ_BYTE) begin
			if (REQ_I.op == OP_MUL_S) begin
				sprod = $signed({{8{REQ_I.dst[7]}}, REQ_I.dst[7:0]}) *
					$signed({{8{REQ_I.src[7]}}, REQ_I.src[7:0]}); // [RULE_08]
				mul_res = {16'h0, sprod[15:0]};
			end else begin
				// widen before multiplying, a bare byte product keeps only eight bits
				uprod = 32'(REQ_I.dst[7:0]) * 32'(REQ_I.src[7:0]);
				mul_res = {16'h0, uprod[15:0]}; // [RULE_07]
			end
		end else begin
			if (REQ_I.op == OP_MUL_S) begin
				sprod = $signed(REQ_I.dst[15:0]) * $signed(REQ_I.src[15:0]); // [RULE_08]
				mul_res = sprod;
			end else begin
				uprod = 32'(REQ_I.dst[15:0]) * 32'(REQ_I.src[15:0]);
				mul_res = uprod; // [RULE_07]
			end
		end
	end

	// ----------------------------------------
	// divide
	// ----------------------------------------
	logic [15:0] div_q;
	logic [15:0] div_r;
	logic        div_zero;
	// divide by zero gives quotient zero and the low half of the dividend as remainder, zero flag set
	arith_divider u_divider (
		.dividend_i (REQ_I.dst),
		.divisor_i  (REQ_I.src[15:0]),
		.wide_i     (REQ_I.size != SZ_BYTE),
		.signed_i   (REQ_I.op == OP_DIV_S),
		.quot_o     (div_q),
		.rem_o      (div_r),
		.zero_div_o (div_zero)
	);

	// ----------------------------------------
	// result assembly
	// ----------------------------------------
	op_res_t     next_res;
	logic [7:0]  next_flags;
	logic [31:0] eff_addr;
	always_comb begin
		next_res = '0;
		next_flags = flags;
		next_res.mem_size = REQ_I.size;
		eff_addr = REQ_I.imm;
		unique case (REQ_I.op)
			OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_BORROW,
			OP_PLUS12, OP_MINUS12, OP_NEGATE: begin
				if (REQ_I.op == OP_SUB && REQ_I.use_imm && REQ_I.size == SZ_BYTE) begin
					next_res.illegal = 1'b1; // [RULE_02]
				end else if ((REQ_I.op == OP_ADD_CARRY || REQ_I.op == OP_SUB_BORROW) &&
					REQ_I.size != SZ_BYTE) begin
					next_res.illegal = 1'b1; // [RULE_03]
				end else begin
					next_res.wr_dst = 1'b1;
					next_res.dst = add_sum; // [RULE_01]
					next_flags[FLG_H] = add_half;
					next_flags[FLG_N] = add_nzvc[3]; // [RULE_19]
					next_flags[FLG_V] = add_nzvc[1];
					next_flags[FLG_C] = add_nzvc[0];
					// chained byte ops keep zero only while the result stays zero
					next_flags[FLG_Z] = (REQ_I.op == OP_ADD_CARRY ||
						REQ_I.op == OP_SUB_BORROW) ? (flags[FLG_Z] & add_nzvc[2]) :
						add_nzvc[2];
					if (REQ_I.op == OP_PLUS12 || REQ_I.op == OP_MINUS12) begin
						next_flags[FLG_C] = flags[FLG_C];
						next_flags[FLG_H] = flags[FLG_H];
					end
				end
			end
			OP_COMPARE: begin
				next_flags[FLG_H] = add_half;
				next_flags[FLG_N] = add_nzvc[3]; // [RULE_11]
				next_flags[FLG_Z] = add_nzvc[2];
				next_flags[FLG_V] = add_nzvc[1];
				next_flags[FLG_C] = add_nzvc[0];
			end
			OP_ADD_SMALL, OP_SUB_SMALL: begin
				next_res.wr_dst = 1'b1;
				next_res.dst = small_res; // [RULE_05]
			end
			OP_DADJ_ADD, OP_DADJ_SUB: begin
				next_res.wr_dst = 1'b1;
				next_res.dst = {24'h0, dadj_res}; // [RULE_06]
				next_flags[FLG_N] = dadj_res[7];
				next_flags[FLG_Z] = (dadj_res == 8'h00);
				next_flags[FLG_C] = dadj_c;
			end
			OP_MUL_U, OP_MUL_S: begin
				next_res.wr_dst = 1'b1;
				next_res.dst = mul_res; // [RULE_07] [RULE_08]
				if (REQ_I.op == OP_MUL_S) begin
					next_flags[FLG_N] = (REQ_I.size == SZ_BYTE) ? mul_res[15] : mul_res[31];
					next_flags[FLG_Z] = (REQ_I.size == SZ_BYTE) ?
						(mul_res[15:0] == 16'h0) : (mul_res == 32'h0);
				end
			end
			OP_DIV_U, OP_DIV_S: begin
				next_res.wr_dst = 1'b1;
				// remainder in the upper half, quotient in the lower
				next_res.dst = (REQ_I.size == SZ_BYTE) ?
					{16'h0, div_r[7:0], div_q[7:0]} : {div_r, div_q}; // [RULE_09] [RULE_10]
				next_flags[FLG_Z] = div_zero;
				next_flags[FLG_N] = (REQ_I.size == SZ_BYTE) ? div_q[7] : div_q[15];
			end
			OP_MOVE_REG: begin
				next_res.wr_dst = 1'b1;
				next_res.dst = REQ_I.use_imm ? REQ_I.imm : REQ_I.src; // [RULE_13]
				unique case (REQ_I.size)
					SZ_BYTE: next_res.dst = {REQ_I.dst[31:8], opnd_b[7:0]};
					SZ_WORD: next_res.dst = {REQ_I.dst[31:16], opnd_b[15:0]};
					default: next_res.dst = opnd_b;
				endcase
				next_flags[FLG_V] = 1'b0;
				next_flags[FLG_N] = (REQ_I.size == SZ_BYTE) ? opnd_b[7] :
					(REQ_I.size == SZ_WORD) ? opnd_b[15] : opnd_b[31];
				next_flags[FLG_Z] = ((opnd_b & (REQ_I.size == SZ_BYTE ? 32'hff :
					REQ_I.size == SZ_WORD ? 32'hffff : 32'hffff_ffff)) == 32'h0);
			end
			OP_LOAD_MEM, OP_STACK_REST: begin
				eff_addr = (REQ_I.op == OP_STACK_REST) ? REQ_I.sp : REQ_I.imm; // [RULE_14]
				next_res.mem_rd = 1'b1;
				next_res.wr_dst = 1'b1;
				unique case (REQ_I.size)
					SZ_BYTE: next_res.dst = {REQ_I.dst[31:8], MEM_RDATA_I[7:0]}; // [RULE_13]
					SZ_WORD: next_res.dst = {REQ_I.dst[31:16], MEM_RDATA_I[15:0]};
					default: next_res.dst = MEM_RDATA_I;
				endcase
				if (REQ_I.op == OP_STACK_REST) begin
					next_res.wr_sp = 1'b1;
					next_res.sp = REQ_I.sp + ((REQ_I.size == SZ_LONG) ? STEP_LONG :
						STEP_WORD); // [RULE_14] [RULE_18]
				end
			end
			OP_STORE_MEM, OP_STACK_SAVE: begin
				next_res.mem_wr = 1'b1;
				next_res.mem_wdata = REQ_I.src; // [RULE_13]
				if (REQ_I.op == OP_STACK_SAVE) begin
					next_res.wr_sp = 1'b1;
					next_res.sp = REQ_I.sp - ((REQ_I.size == SZ_LONG) ? STEP_LONG :
						STEP_WORD); // [RULE_15]
					eff_addr = next_res.sp;
				end
			end
			OP_PSYNC_LOAD, OP_PSYNC_STOR: begin
				// no peripheral strobe exists behind this block, so report only
				next_res.illegal = 1'b1; // [RULE_16]
			end
			default: next_res.illegal = 1'b1;
		endcase
		// wide accesses ignore the lowest address bit
		next_res.mem_addr = (REQ_I.size == SZ_BYTE) ? eff_addr :
			(eff_addr & ADDR_ALIGN); // [RULE_17]
		if (!(next_res.mem_rd || next_res.mem_wr)) begin
			next_res.mem_addr = 32'h0;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			RES_VALID_O <= 1'b0;
			RES_O <= '0;
		end else begin
			RES_VALID_O <= REQ_VALID_I;
			if (REQ_VALID_I) begin
				RES_O <= next_res;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			flags <= FLAGS_RESET;
		end else if (REQ_VALID_I) begin
			// flags hold while idle so a later adjust or carry op sees the last result
			flags <= next_flags; // [RULE_19]
		end
	end

	assign FLAGS_O = flags;
endmodule

// *** arith_datapath_asserts.sv ***
// concurrent checks on the ports of the arithmetic datapath
`timescale 1ns/1ps
module arith_datapath_asserts
	import arith_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_B_I,
	// request side
	input  wire logic        REQ_VALID_I,
	input  wire op_req_t     REQ_I,
	input  wire logic [31:0] MEM_RDATA_I,
	// result side
	input  wire logic        RES_VALID_O,
	input  wire op_res_t     RES_O,
	input  wire logic [7:0]  FLAGS_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	// ----------------------------------------
	// request steps
	// ----------------------------------------
	sequence save_long;
		REQ_VALID_I && REQ_I.op == OP_STACK_SAVE && REQ_I.size == SZ_LONG;
	endsequence
	sequence rest_word;
		REQ_VALID_I && REQ_I.op == OP_STACK_REST && REQ_I.size == SZ_WORD;
	endsequence
	sequence bad_op;
		REQ_VALID_I && (REQ_I.op inside {OP_PSYNC_LOAD, OP_PSYNC_STOR} ||
			(REQ_I.op == OP_SUB && REQ_I.size == SZ_BYTE && REQ_I.use_imm));
	endsequence

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_answer_next: assert property (REQ_VALID_I |=> RES_VALID_O)
		else $error("result missing one cycle after request");
	a_no_spurious: assert property (!REQ_VALID_I |=> !RES_VALID_O)
		else $error("result without request");
	a_idle_hold: assert property (!REQ_VALID_I |=> $stable(FLAGS_O) && $stable(RES_O))
		else $error("outputs moved while idle");
	a_refused_op: assert property (bad_op |=> RES_O.illegal && !RES_O.wr_dst &&
		!RES_O.wr_sp && !RES_O.mem_wr && $stable(FLAGS_O))
		else $error("refused operation had an effect");
	a_cmp_nowrite: assert property (REQ_VALID_I && REQ_I.op == OP_COMPARE |=> !RES_O.wr_dst)
		else $error("compare wrote back");
	a_save_step: assert property (save_long |=> RES_O.wr_sp && RES_O.mem_wr &&
		RES_O.sp == $past(REQ_I.sp) - STEP_LONG && RES_O.mem_addr == (RES_O.sp & ADDR_ALIGN))
		else $error("stack save step wrong");
	a_rest_step: assert property (rest_word |=> RES_O.mem_rd &&
		RES_O.sp == $past(REQ_I.sp) + STEP_WORD &&
		RES_O.dst[15:0] == $past(MEM_RDATA_I[15:0]))
		else $error("stack restore step wrong");
	a_even_addr: assert property (RES_VALID_O && (RES_O.mem_rd || RES_O.mem_wr) &&
		RES_O.mem_size != SZ_BYTE |-> !RES_O.mem_addr[0])
		else $error("odd word address");
	a_small_const: assert property (REQ_VALID_I && REQ_I.op == OP_ADD_SMALL |=>
		RES_O.dst == $past(REQ_I.dst) + {29'h0, $past(REQ_I.small_const)} && $stable(FLAGS_O))
		else $error("small constant add wrong");
endmodule

// *** arith_datapath_test.sv ***
// self-checking testbench of the arithmetic datapath
`timescale 1ns/1ps
module arith_datapath_test;
	import arith_pkg::*;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        req_valid = 1'b0;
	op_req_t     req = '0;
	logic [31:0] mem_rdata;
	logic        res_valid;
	op_res_t     res;
	logic [7:0]  flags;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;

	always #50 clk = ~clk;

	arith_datapath u_arith_datapath (.CLK_I(clk), .RST_B_I(rst_b), .REQ_VALID_I(req_valid),
		.REQ_I(req), .MEM_RDATA_I(mem_rdata), .RES_VALID_O(res_valid), .RES_O(res),
		.FLAGS_O(flags));
	arith_mem_model u_arith_mem_model (.req_i(req), .rdata_o(mem_rdata));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [95:0] s, input logic [95:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask

	// one request, results checked after the answer edge has landed
	task automatic go(input op_code_t o, input op_size_t z, input logic i, input logic [2:0] k,
		input logic [31:0] d, input logic [31:0] s, input logic [31:0] m, input logic [31:0] p);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{o, z, i, k, d, s, m, p};
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		chk("res_valid", res_valid, 1'b1);
	endtask

	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_add_sub();
		go(OP_ADD, SZ_BYTE, 0, 0, 32'h7f, 32'h01, 0, 0);
		chk("add b", res.dst[7:0], 8'h80);
		chk("add b nzvc", flags[3:0], 4'ha);
		go(OP_ADD, SZ_WORD, 1, 0, 32'hffff, 0, 32'h1, 0);
		chk("add w", res.dst[15:0], 16'h0);
		chk("add w nzvc", flags[3:0], 4'h5);
		go(OP_SUB, SZ_LONG, 1, 0, 0, 0, 32'h1, 0);
		chk("sub l", res.dst, 32'hffff_ffff);
		chk("sub l nzvc", flags[3:0], 4'h9);
		go(OP_SUB, SZ_BYTE, 1, 0, 32'h5, 0, 32'h1, 0);
		chk("sub imm b", {res.illegal, res.wr_dst}, 2'b10);
		chk("sub imm flags", flags[3:0], 4'h9);
	endtask

	task automatic t_carry();
		go(OP_ADD_CARRY, SZ_BYTE, 0, 0, 32'h10, 32'h20, 0, 0);
		chk("addc", res.dst[7:0], 8'h31);
		go(OP_SUB_BORROW, SZ_BYTE, 1, 0, 32'h10, 0, 32'h1, 0);
		chk("subb", res.dst[7:0], 8'h0f);
		go(OP_ADD_CARRY, SZ_WORD, 0, 0, 32'h10, 32'h20, 0, 0);
		chk("addc w", res.illegal, 1'b1);
	endtask

	task automatic t_step();
		go(OP_PLUS12, SZ_WORD, 0, 3'h2, 32'h7ffe, 0, 0, 0);
		chk("inc2 w", res.dst[15:0], 16'h8000);
		chk("inc nzvc", flags[3:0], 4'ha);
		go(OP_PLUS12, SZ_BYTE, 0, 3'h2, 32'h05, 0, 0, 0);
		chk("inc b", res.dst[7:0], 8'h06);
		go(OP_MINUS12, SZ_LONG, 0, 3'h1, 0, 0, 0, 0);
		chk("dec l", res.dst, 32'hffff_ffff);
		go(OP_ADD_SMALL, SZ_LONG, 0, 3'h4, 32'hffff_fffe, 0, 0, 0);
		chk("adds 4", res.dst, 32'h2);
		chk("adds flags", flags[3:0], 4'h8);
		go(OP_SUB_SMALL, SZ_LONG, 0, 3'h2, 32'h1, 0, 0, 0);
		chk("sub_small_const 2", res.dst, 32'hffff_ffff);
	endtask

	task automatic t_dadj();
		go(OP_ADD, SZ_BYTE, 0, 0, 32'h19, 32'h28, 0, 0);
		chk("add h", flags[FLG_H], 1'b1);
		go(OP_DADJ_ADD, SZ_BYTE, 0, 0, res.dst, 0, 0, 0);
		chk("daa", res.dst[7:0], 8'h47);
		go(OP_SUB, SZ_BYTE, 0, 0, 32'h47, 32'h19, 0, 0);
		go(OP_DADJ_SUB, SZ_BYTE, 0, 0, res.dst, 0, 0, 0);
		chk("das", res.dst[7:0], 8'h28);
	endtask

	task automatic t_muldiv();
		go(OP_MUL_U, SZ_BYTE, 0, 0, 32'hff, 32'hff, 0, 0);
		chk("mulu b", res.dst[15:0], 16'hfe01);
		go(OP_MUL_U, SZ_WORD, 0, 0, 32'hffff, 32'hffff, 0, 0);
		chk("mulu w", res.dst, 32'hfffe_0001);
		go(OP_MUL_S, SZ_BYTE, 0, 0, 32'hff, 32'h02, 0, 0);
		chk("muls b", res.dst[15:0], 16'hfffe);
		go(OP_MUL_S, SZ_WORD, 0, 0, 32'hffff, 32'h2, 0, 0);
		chk("muls w", res.dst, 32'hffff_fffe);
		go(OP_DIV_U, SZ_BYTE, 0, 0, 32'h64, 32'h07, 0, 0);
		chk("divu b", res.dst[15:0], 16'h020e);
		go(OP_DIV_U, SZ_WORD, 0, 0, 32'h186a0, 32'h7, 0, 0);
		chk("divu w", res.dst, 32'h0005_37cd);
		go(OP_DIV_S, SZ_BYTE, 0, 0, 32'hff9c, 32'h07, 0, 0);
		chk("divs b", res.dst[15:0], 16'hfef2);
		go(OP_DIV_U, SZ_BYTE, 0, 0, 32'h64, 0, 0, 0);
		chk("div zero", {res.dst[15:0], flags[FLG_Z]}, {16'h6400, 1'b1});
	endtask

	task automatic t_cmp_neg_mov();
		go(OP_COMPARE, SZ_LONG, 1, 0, 32'h5, 0, 32'h5, 0);
		chk("cmp", {res.wr_dst, flags[3:0]}, 5'h04);
		go(OP_NEGATE, SZ_WORD, 0, 0, 32'h8000, 0, 0, 0);
		chk("neg w", res.dst[15:0], 16'h8000);
		chk("neg nzvc", flags[3:0], 4'hb);
		go(OP_MOVE_REG, SZ_BYTE, 0, 0, 32'haaaa_aaaa, 32'h1234_5678, 0, 0);
		chk("mov b", res.dst, 32'haaaa_aa78);
		go(OP_MOVE_REG, SZ_LONG, 1, 0, 0, 0, 32'h8000_0000, 0);
		chk("mov imm", {res.dst, flags[FLG_N]}, {32'h8000_0000, 1'b1});
		go(OP_LOAD_MEM, SZ_WORD, 0, 0, 0, 0, 32'h1001, 0);
		chk("ld addr", res.mem_addr, 32'h1000);
		chk("ld data", {res.mem_rd, res.dst[15:0]}, {1'b1, ~16'h1000});
		go(OP_STORE_MEM, SZ_LONG, 0, 0, 0, 32'hcafe_f00d, 32'h2003, 0);
		chk("st addr", res.mem_addr, 32'h2002);
		chk("st data", {res.mem_wr, res.wr_dst, res.mem_wdata}, {2'b10, 32'hcafe_f00d});
	endtask

	// stack pointer values stay even throughout
	task automatic t_stack();
		go(OP_STACK_SAVE, SZ_LONG, 0, 0, 0, 32'hdead_beef, 0, 32'h100);
		chk("push l", {res.sp, res.mem_addr, res.mem_wdata}, {64'hfc_0000_00fc, 32'hdead_beef});
		go(OP_STACK_SAVE, SZ_WORD, 0, 0, 0, 32'h1234, 0, 32'h100);
		chk("push w", res.sp, 32'hfe);
		go(OP_STACK_REST, SZ_WORD, 0, 0, 0, 0, 0, 32'hfc);
		chk("pop w", {res.sp, res.mem_addr, res.dst[15:0]}, {64'hfe_0000_00fc, ~16'h00fc});
		go(OP_STACK_REST, SZ_LONG, 0, 0, 0, 0, 0, 32'hfc);
		chk("pop l", {res.sp, res.dst}, {32'h100, pat(32'hfc)});
	endtask

	task automatic t_refused();
		go(OP_PSYNC_LOAD, SZ_BYTE, 0, 0, 0, 0, 32'h10, 0);
		chk("psync ld", {res.illegal, res.wr_dst}, 2'b10);
		go(OP_PSYNC_STOR, SZ_BYTE, 0, 0, 0, 32'h1, 32'h10, 0);
		chk("psync st", {res.illegal, res.mem_wr}, 2'b10);
	endtask

	// two requests on consecutive edges
	task automatic t_b2b();
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{OP_ADD, SZ_LONG, 1'b0, 3'h0, 32'h1, 32'h2, 32'h0, 32'h0};
		@(posedge clk);
		req <= '{OP_ADD, SZ_LONG, 1'b0, 3'h0, 32'h3, 32'h4, 32'h0, 32'h0};
		#1;
		chk("b2b 1", {res_valid, res.dst}, {1'b1, 32'h3});
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		chk("b2b 2", {res_valid, res.dst}, {1'b1, 32'h7});
		@(posedge clk);
		#1;
		chk("b2b idle", res_valid, 1'b0);
	endtask

	// ----------------------------------------
	// run and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		#1;
		chk("rst flags", flags, FLAGS_RESET);
		chk("rst valid", res_valid, 1'b0);
		@(posedge clk);
		rst_b <= 1'b1;
		t_add_sub();
		t_carry();
		t_step();
		t_dadj();
		t_muldiv();
		t_cmp_neg_mov();
		t_stack();
		t_refused();
		t_b2b();
		complete_run();
	end
endmodule

bind arith_datapath arith_datapath_asserts u_arith_datapath_asserts (.CLK_I(CLK_I),
	.RST_B_I(RST_B_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .MEM_RDATA_I(MEM_RDATA_I),
	.RES_VALID_O(RES_VALID_O), .RES_O(RES_O), .FLAGS_O(FLAGS_O));

// *** arith_divider.sv ***
// combinational divider for 16/8 and 32/16, signed or unsigned
`timescale 1ns/1ps
module arith_divider
	import arith_pkg::*;
(
	// operands
	input  wire logic [31:0] dividend_i,
	input  wire logic [15:0] divisor_i,
	input  wire logic        wide_i,
	input  wire logic        signed_i,
	// result
	output logic      [15:0] quot_o,
	output logic      [15:0] rem_o,
	output logic             zero_div_o
);
	// ----------------------------------------
	// magnitude divide, then restore signs
	// ----------------------------------------
	logic [31:0] dd;
	logic [15:0] dv;
	logic        sdd;
	logic        sdv;
	logic [31:0] q;
	logic [31:0] r;
	always_comb begin
		sdd = signed_i & (wide_i ? dividend_i[31] : dividend_i[15]);
		sdv = signed_i & (wide_i ? divisor_i[15] : divisor_i[7]);
		dd = wide_i ? dividend_i : {16'h0, dividend_i[15:0]};
		dv = wide_i ? divisor_i : {8'h0, divisor_i[7:0]};
		if (sdd) begin
			dd = wide_i ? (32'h0 - dd) : {16'h0, 16'h0 - dd[15:0]};
		end
		if (sdv) begin
			dv = wide_i ? (16'h0 - dv) : {8'h0, 8'h0 - dv[7:0]};
		end
		zero_div_o = (dv == 16'h0000);
		q = zero_div_o ? 32'h0 : dd / {16'h0, dv};
		r = zero_div_o ? dd : dd % {16'h0, dv};
		if (sdd ^ sdv) begin
			q = 32'h0 - q;
		end
		if (sdd) begin
			r = 32'h0 - r;
		end
		quot_o = wide_i ? q[15:0] : {8'h0, q[7:0]};
		rem_o = wide_i ? r[15:0] : {8'h0, r[7:0]};
	end
endmodule

// *** arith_mem_model.sv ***
// memory seen by the datapath: answers loads in the request cycle
`timescale 1ns/1ps
module arith_mem_model
	import arith_pkg::*;
(
	// request
	input  wire op_req_t     req_i,
	// load data
	output logic      [31:0] rdata_o
);
	logic [31:0] addr;
	logic        rd;

	// the bus ignores bit 0 on every access, byte accesses included
	always_comb begin
		addr = (req_i.op == OP_STACK_REST) ? req_i.sp : req_i.imm;
		addr[0] = 1'b0;
		rd = req_i.op inside {OP_LOAD_MEM, OP_STACK_REST};
		// outside a load the lines carry the swapped pattern, never a clean copy
		rdata_o = rd ? {addr[15:0], ~addr[15:0]} : {~addr[15:0], addr[15:0]};
	end
endmodule

// *** arith_pkg.sv ***
// package with operation codes, sizes, flag positions and carriers for the arithmetic datapath
package arith_pkg;

	// ----------------------------------------
	// operand sizes and operations
	// ----------------------------------------
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} op_size_t;

	typedef enum logic [4:0] {
		OP_ADD        = 5'h00,
		OP_SUB        = 5'h01,
		OP_ADD_CARRY  = 5'h02,
		OP_SUB_BORROW = 5'h03,
		OP_PLUS12     = 5'h04,
		OP_MINUS12    = 5'h05,
		OP_ADD_SMALL  = 5'h06,
		OP_SUB_SMALL  = 5'h07,
		OP_DADJ_ADD   = 5'h08,
		OP_DADJ_SUB   = 5'h09,
		OP_MUL_U      = 5'h0a,
		OP_MUL_S      = 5'h0b,
		OP_DIV_U      = 5'h0c,
		OP_DIV_S      = 5'h0d,
		OP_COMPARE    = 5'h0e,
		OP_NEGATE     = 5'h0f,
		OP_MOVE_REG   = 5'h10,
		OP_LOAD_MEM   = 5'h11,
		OP_STORE_MEM  = 5'h12,
		OP_STACK_REST = 5'h13,
		OP_STACK_SAVE = 5'h14,
		OP_PSYNC_LOAD = 5'h15,
		OP_PSYNC_STOR = 5'h16
	} op_code_t;

	// ----------------------------------------
	// condition flag positions and reset values
	// ----------------------------------------
	localparam int FLG_C = 0;
	localparam int FLG_V = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam int FLG_H = 5;
	localparam logic [7:0] FLAGS_RESET  = 8'h80;
	localparam logic [3:0] DIV_CYCLES   = 4'h0;
	localparam logic [31:0] ADDR_ALIGN  = 32'hffff_fffe;
	localparam logic [31:0] STEP_WORD   = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG   = 32'h0000_0004;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		op_code_t   op;
		op_size_t   size;
		logic       use_imm;
		logic [2:0] small_const;
		logic [31:0] dst;
		logic [31:0] src;
		logic [31:0] imm;
		logic [31:0] sp;
	} op_req_t;

	typedef struct packed {
		logic        wr_dst;
		logic [31:0] dst;
		logic        wr_sp;
		logic [31:0] sp;
		logic        mem_rd;
		logic        mem_wr;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		op_size_t    mem_size;
		logic        illegal;
	} op_res_t;

endpackage
